/* hdl/dsleep_consts.svh */
/*
 Offsets, field positions, reset values and timing counts for the
 deep-sleep, soft-reset and PLL-lock slice. Included by bare name.
 Bit positions are LSB-first indices (printed position p -> 31-p).
*/
// What this block does
// - Oscillator-disable bit stops the internal oscillator; clear keeps it running.
// - Sequencer enable lets quiesce request start deep sleep; clear forbids sleep.
// - Deep sleep entered by the sequencer stops every device clock.
// - Oscillator-sleep bit lets sleep stop oscillator; clear keeps it running.
// - Test bit 0 forces quiesce active; 1 passes the core request.
// - Writing 1 to soft-reset bit resets; the bit then clears itself.
// - Lock bit reads 1 once PLL lock detected, else 0.
// - Lost-lock bit set by hardware after lock loss, cleared by write.
// - Window bit: 1 gives 2 VCO periods window, 0 gives 4.
// - Lock after 1024 reference edges all inside the feedback window.
// - In bypass, lock after 1024 oscillator clock rising edges.
// - Lock logic is informational; clocks never wait, no interrupt.
`ifndef DSLEEP_CONSTS_SVH
`define DSLEEP_CONSTS_SVH
`define OSC_CFG_OFF 12'h218
`define SEQ_CFG_OFF 12'h21C
`define SRST_OFF 12'h220
`define LOCK_STA_OFF 12'h224
`define OSC_DIS_BIT 24
`define SLEEP_EN_BIT 24
`define OSC_SLEEP_BIT 16
`define QTEST_BIT 0
`define SRST_BIT 24
`define LOCK_BIT 24
`define LOST_BIT 16
`define WIN_BIT 8
`define OSC_DIS_RST 1'b0
`define SLEEP_EN_RST 1'b1
`define OSC_SLEEP_RST 1'b1
`define QTEST_RST 1'b1
`define WIN_RST 1'b1
`define LOCK_EDGES 1024
`define WIN_SMALL 3'h2
`define WIN_LARGE 3'h4
`define CLK_MHZ 125
`define SRST_MIN_NS 16
`define SRST_CYCLES ((`SRST_MIN_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_NS 2000
`define SETTLE_CYCLES ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* hdl/dsleep_pkg.sv */
/*
 Types shared by the deep-sleep slice.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package dsleep_pkg;
   // Gray along run -> gate -> sleep -> settle -> run
   typedef enum logic [1:0] {
      SEQ_RUN = 2'b00,
      SEQ_GATE = 2'b01,
      SEQ_SLEEP = 2'b11,
      SEQ_SETTLE = 2'b10
   } seq_state_type;
   typedef logic [31:0] word_type;
endpackage
`default_nettype wire

/* hdl/sleep_sequencer.sv */
/*
 Deep-sleep clock sequencer: gates clocks on quiesce, may stop the
 oscillator, restarts and settles it on wake.
 Assumes quiesce and wake inputs synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsleep_consts.svh"
module sleep_sequencer
   import dsleep_pkg::*;
#(
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Configuration
   input wire logic sleep_enable,
   input wire logic osc_sleep_enable,
   input wire logic osc_disable,
   // Core handshake
   input wire logic quiesce_req,
   input wire logic wake_req,
   // Clock controls
   output logic clocks_stop,
   output logic osc_enable,
   output logic quiesce_ack
);
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk
      $error("SETTLE_CYCLES out of range");
   end
   seq_state_type state, next_state;
   logic [15:0] count, next_count;
   logic osc_off, next_osc_off;

   // Next state and clock controls
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         SEQ_RUN: begin
            if (sleep_enable && quiesce_req) begin
               next_state = SEQ_GATE;
            end
         end
         SEQ_GATE: next_state = SEQ_SLEEP;
         SEQ_SLEEP: begin
            if (wake_req) begin
               next_state = SEQ_SETTLE;
               // Stopped oscillator needs full settle time
               next_count = osc_off ? 16'(SETTLE_CYCLES) : 16'h0001;
            end
         end
         SEQ_SETTLE: begin
            if (count <= 16'h0001) begin
               next_state = SEQ_RUN;
            end else begin
               next_count = count - 16'h0001;
            end
         end
         default: next_state = SEQ_RUN;
      endcase
      next_osc_off = (next_state == SEQ_SLEEP) && osc_sleep_enable;
   end

   // Registered state and outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SEQ_RUN;
         count <= 16'h0000;
         osc_off <= 1'b0;
         clocks_stop <= 1'b0;
         osc_enable <= 1'b1;
         quiesce_ack <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         osc_off <= next_osc_off;
         clocks_stop <= (next_state != SEQ_RUN);
         osc_enable <= !osc_disable && !next_osc_off;
         quiesce_ack <= (next_state == SEQ_SLEEP);
      end
   end

   // Checks on the sequencer's own outputs
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_enter;
      clocks_stop ##1 (clocks_stop && quiesce_ack);
   endsequence

   property p_osc_off;
      osc_disable |=> !osc_enable;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator still enabled while disabled");

   property p_no_sleep;
      !sleep_enable && !clocks_stop |=> !clocks_stop;
   endproperty
   a_no_sleep: assert property (p_no_sleep)
      else $error("sleep entered while sequencer disabled");

   property p_sleep_entry;
      sleep_enable && quiesce_req && !clocks_stop |=> s_enter;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("deep sleep not entered on quiesce");

   property p_osc_kept;
      quiesce_ack && !$past(osc_sleep_enable) && !$past(osc_disable)
         |-> osc_enable;
   endproperty
   a_osc_kept: assert property (p_osc_kept)
      else $error("oscillator stopped though sleep stop not allowed");

   property p_wake;
      quiesce_ack && wake_req && !osc_enable && !osc_disable
         |=> osc_enable && clocks_stop;
   endproperty
   a_wake: assert property (p_wake)
      else $error("clocks released before oscillator restart");
endmodule
`default_nettype wire

/* hdl/lock_detect.sv */
/*
 PLL lock monitor. Reference, feedback, VCO and oscillator clocks
 arrive as sampled levels; aclk must be fast enough to see each edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsleep_consts.svh"
module lock_detect #(
   parameter int LOCK_EDGES = `LOCK_EDGES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sampled PLL clocks
   input wire logic synth_reference_clock,
   input wire logic synth_feedback_clock,
   input wire logic synth_vco_clock,
   input wire logic osc_clock,
   // Mode
   input wire logic pll_bypass,
   input wire logic small_window,
   // Status
   output logic locked,
   output logic lost_pulse
);
   if (LOCK_EDGES < 2 || LOCK_EDGES > 65535) begin : g_chk
      $error("LOCK_EDGES out of range");
   end
   logic [3:0] prev, next_prev;
   logic [2:0] win, next_win;
   logic [15:0] cnt, next_cnt;
   logic next_locked, next_lost;
   logic ref_rise, fb_rise, vco_rise, osc_rise, in_win;

   // Edge detection on sampled levels
   assign ref_rise = synth_reference_clock && !prev[0];
   assign fb_rise = synth_feedback_clock && !prev[1];
   assign vco_rise = synth_vco_clock && !prev[2];
   assign osc_rise = osc_clock && !prev[3];
   assign in_win = fb_rise || (win != 3'h0);

   // Window and edge counting
   always_comb begin
      next_prev = {osc_clock, synth_vco_clock, synth_feedback_clock,
                   synth_reference_clock};
      next_win = win;
      next_cnt = cnt;
      next_locked = locked;
      next_lost = 1'b0;
      if (fb_rise) begin
         next_win = small_window ? `WIN_SMALL : `WIN_LARGE;
      end else if (vco_rise && win != 3'h0) begin
         next_win = win - 3'h1;
      end
      if (pll_bypass) begin
         if (osc_rise && !locked) begin
            next_cnt = cnt + 16'h0001;
            next_locked = (next_cnt == 16'(LOCK_EDGES));
         end
      end else if (ref_rise) begin
         if (in_win) begin
            if (!locked) begin
               next_cnt = cnt + 16'h0001;
               next_locked = (next_cnt == 16'(LOCK_EDGES));
            end
         end else begin
            next_cnt = 16'h0000;
            next_locked = 1'b0;
            next_lost = locked;
         end
      end
   end

   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev <= 4'h0;
         win <= 3'h0;
         cnt <= 16'h0000;
         locked <= 1'b0;
         lost_pulse <= 1'b0;
      end else begin
         prev <= next_prev;
         win <= next_win;
         cnt <= next_cnt;
         locked <= next_locked;
         lost_pulse <= next_lost;
      end
   end
endmodule
`default_nettype wire

/* hdl/deep_sleep_reset_pll_monitor.sv */
/*
 Top of the slice: AXI4-Lite register slave, soft-reset pulse, and
 the sleep sequencer and lock monitor instances.
 Assumes a single-master AXI4-Lite bus on aclk; all pins synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsleep_consts.svh"
module deep_sleep_reset_pll_monitor
   import dsleep_pkg::*;
#(
   parameter int SRST_CYCLES = `SRST_CYCLES,
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
   parameter int LOCK_EDGES = `LOCK_EDGES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Processor core
   input wire logic core_quiesce_req,
   input wire logic wake_req,
   output logic quiesce_ack,
   // Clock controls
   output logic clocks_stop,
   output logic osc_enable,
   output logic soft_reset,
   // PLL monitor inputs
   input wire logic synth_reference_clock,
   input wire logic synth_feedback_clock,
   input wire logic synth_vco_clock,
   input wire logic osc_clock,
   input wire logic pll_bypass,
   output logic pll_locked
);
   if (SRST_CYCLES < 1 || SRST_CYCLES > 255) begin : g_chk
      $error("SRST_CYCLES out of range");
   end

   // True for one of the four mapped words
   function automatic logic mapped(input logic [11:0] a);
      return (a == `OSC_CFG_OFF) || (a == `SEQ_CFG_OFF) ||
             (a == `SRST_OFF) || (a == `LOCK_STA_OFF);
   endfunction

   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [11:0] wr_addr, next_wr_addr;
   word_type wr_data, next_wr_data;
   logic [3:0] wr_strb, next_wr_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   word_type next_rdata, read_word, wr_word;
   logic wr_en;

   logic osc_dis, next_osc_dis;
   logic sleep_en, next_sleep_en;
   logic osc_sleep, next_osc_sleep;
   logic qtest, next_qtest;
   logic win_small, next_win_small;
   logic lost, next_lost, lost_clr;
   logic [7:0] srst_cnt, next_srst_cnt;
   logic next_soft_reset, lost_pulse, qreq;

   // Write happens once address and data are both held
   assign wr_en = aw_held && w_held && !s_axi_bvalid;

   // Register read view; reserved bits read zero
   always_comb begin
      read_word = 32'h00000000;
      case (s_axi_araddr)
         `OSC_CFG_OFF: read_word[`OSC_DIS_BIT] = osc_dis;
         `SEQ_CFG_OFF: begin
            read_word[`SLEEP_EN_BIT] = sleep_en;
            read_word[`OSC_SLEEP_BIT] = osc_sleep;
            read_word[`QTEST_BIT] = qtest;
         end
         `SRST_OFF: read_word[`SRST_BIT] = soft_reset;
         `LOCK_STA_OFF: begin
            read_word[`LOCK_BIT] = pll_locked;
            read_word[`LOST_BIT] = lost;
            read_word[`WIN_BIT] = win_small;
         end
         default: read_word = 32'h00000000;
      endcase
   end

   // Bus handshakes: one write and one read in flight
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_wr_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wr_data = s_axi_wdata;
         next_wr_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_en) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = read_word;
         next_rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Ready drops while a response is pending
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 12'h000;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // Register updates; only defined fields are stored
   always_comb begin
      wr_word = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};
      next_osc_dis = osc_dis;
      next_sleep_en = sleep_en;
      next_osc_sleep = osc_sleep;
      next_qtest = qtest;
      next_win_small = win_small;
      next_srst_cnt = srst_cnt;
      next_soft_reset = soft_reset;
      lost_clr = 1'b0;
      if (wr_en) begin
         case (wr_addr)
            `OSC_CFG_OFF: begin
               if (wr_strb[`OSC_DIS_BIT/8]) begin
                  next_osc_dis = wr_word[`OSC_DIS_BIT];
               end
            end
            `SEQ_CFG_OFF: begin
               if (wr_strb[`SLEEP_EN_BIT/8]) begin
                  next_sleep_en = wr_word[`SLEEP_EN_BIT];
               end
               if (wr_strb[`OSC_SLEEP_BIT/8]) begin
                  next_osc_sleep = wr_word[`OSC_SLEEP_BIT];
               end
               if (wr_strb[`QTEST_BIT/8]) begin
                  next_qtest = wr_word[`QTEST_BIT];
               end
            end
            `SRST_OFF: begin
               if (wr_word[`SRST_BIT] && !soft_reset) begin
                  next_srst_cnt = 8'(SRST_CYCLES);
                  next_soft_reset = 1'b1;
               end
            end
            `LOCK_STA_OFF: begin
               // Lost flag is write-one-to-clear
               lost_clr = wr_word[`LOST_BIT];
               if (wr_strb[`WIN_BIT/8]) begin
                  next_win_small = wr_word[`WIN_BIT];
               end
            end
            default: lost_clr = 1'b0;
         endcase
      end
      // Pulse counts down, then the bit clears itself
      if (soft_reset && !(wr_en && wr_addr == `SRST_OFF)) begin
         if (srst_cnt <= 8'h01) begin
            next_soft_reset = 1'b0;
            next_srst_cnt = 8'h00;
         end else begin
            next_srst_cnt = srst_cnt - 8'h01;
         end
      end
      // A loss in the clearing cycle still wins
      next_lost = lost_pulse || (lost && !lost_clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_dis <= `OSC_DIS_RST;
         sleep_en <= `SLEEP_EN_RST;
         osc_sleep <= `OSC_SLEEP_RST;
         qtest <= `QTEST_RST;
         win_small <= `WIN_RST;
         lost <= 1'b0;
         srst_cnt <= 8'h00;
         soft_reset <= 1'b0;
      end else begin
         osc_dis <= next_osc_dis;
         sleep_en <= next_sleep_en;
         osc_sleep <= next_osc_sleep;
         qtest <= next_qtest;
         win_small <= next_win_small;
         lost <= next_lost;
         srst_cnt <= next_srst_cnt;
         soft_reset <= next_soft_reset;
      end
   end

   // Test bit low forces quiesce for simulation
   assign qreq = qtest ? core_quiesce_req : 1'b1;

   // Lock status never feeds the sequencer: clocks do not wait
   sleep_sequencer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .sleep_enable(sleep_en),
      .osc_sleep_enable(osc_sleep),
      .osc_disable(osc_dis),
      .quiesce_req(qreq),
      .wake_req(wake_req),
      .clocks_stop(clocks_stop),
      .osc_enable(osc_enable),
      .quiesce_ack(quiesce_ack)
   );

   lock_detect #(
      .LOCK_EDGES(LOCK_EDGES)
   ) u_lock (
      .aclk(aclk),
      .aresetn(aresetn),
      .synth_reference_clock(synth_reference_clock),
      .synth_feedback_clock(synth_feedback_clock),
      .synth_vco_clock(synth_vco_clock),
      .osc_clock(osc_clock),
      .pll_bypass(pll_bypass),
      .small_window(win_small),
      .locked(pll_locked),
      .lost_pulse(lost_pulse)
   );

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_qtest;
      !qtest && sleep_en && !clocks_stop |=> clocks_stop;
   endproperty
   a_qtest: assert property (p_qtest)
      else $error("forced quiesce did not start sleep");

   property p_srst_clear;
      $rose(soft_reset) |-> ##[1:8] !soft_reset;
   endproperty
   a_srst_clear: assert property (p_srst_clear)
      else $error("soft reset bit did not clear itself");

   property p_srst_hold;
      $rose(soft_reset) |-> soft_reset [*2];
   endproperty
   a_srst_hold: assert property (p_srst_hold)
      else $error("soft reset shorter than required");

   property p_lock_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `LOCK_STA_OFF
         |=> s_axi_rdata[`LOCK_BIT] == $past(pll_locked);
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("lock bit read back wrong");

   property p_lost_set;
      lost_pulse |=> lost;
   endproperty
   a_lost_set: assert property (p_lost_set)
      else $error("lost lock flag not set");

   property p_lost_sticky;
      lost && !lost_clr |=> lost;
   endproperty
   a_lost_sticky: assert property (p_lost_sticky)
      else $error("lost lock flag cleared without a write");
endmodule
`default_nettype wire

/* tb/core_model.sv */
/*
 Processor core stand-in: raises quiesce on command until acknowledged,
 then raises wake on command until the acknowledge drops.
 Assumes commands are aclk-synchronous levels from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module core_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench commands and block answer
   input wire logic go_sleep,
   input wire logic go_wake,
   input wire logic quiesce_ack,
   // Requests to the block
   output logic core_quiesce_req,
   output logic wake_req
);
   // Hold each request until answered, as a real core would
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_quiesce_req <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         core_quiesce_req <= go_sleep | (core_quiesce_req & ~quiesce_ack);
         wake_req <= go_wake | (wake_req & quiesce_ack);
      end
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 Self-checking bench: AXI4-Lite master tasks, PLL edge stimulus, core.
 Assumes short parameters: settle 4, lock 4 edges, soft reset 2.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dsleep_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, gs = 0, gw = 0, refc = 0, fbk = 0;
   logic vco = 0, osc = 0, byp = 0, awready, wready, bvalid, arready;
   logic rvalid, cq, wk, ack, cstop, osc_en, srst, locked;
   logic [11:0] awaddr = 0, araddr = 0;
   word_type wdata = 0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   int errors = 0, check_count = 0, n, r;
   deep_sleep_reset_pll_monitor #(.SRST_CYCLES(2), .SETTLE_CYCLES(4),
      .LOCK_EDGES(4)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_quiesce_req(cq), .wake_req(wk),
      .quiesce_ack(ack), .clocks_stop(cstop), .osc_enable(osc_en),
      .soft_reset(srst), .synth_reference_clock(refc),
      .synth_feedback_clock(fbk), .synth_vco_clock(vco),
      .osc_clock(osc), .pll_bypass(byp), .pll_locked(locked));
   core_model core (.aclk(aclk), .aresetn(aresetn), .go_sleep(gs),
      .go_wake(gw), .quiesce_ack(ack), .core_quiesce_req(cq),
      .wake_req(wk));
   // 125 MHz clock; VCO stand-in toggles on every aclk rising edge
   initial forever #4 aclk = ~aclk;
   always @(posedge aclk) vco <= ~vco;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input word_type d);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      // Ready left high so back-to-back calls never drive it twice
      rs = bresp;
   endtask
   task automatic rdr(input logic [11:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // Feedback and reference rise together when good; reference alone if not
   task automatic pll(input logic good, input int k);
      repeat (k) begin
         @(posedge aclk); fbk <= good; refc <= 1;
         cyc(2); fbk <= 0; refc <= 0; cyc(12);
      end
   endtask
   task automatic end_of_test;
      if (errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin cyc(20000); errors++; end_of_test; end
   initial begin
      r = $urandom(32'h2d5e);
      cyc(5); aresetn <= 1; cyc(2);
      rdr(12'h218); chk(rd, 32'h0);
      chk(32'(rs), 32'h0);
      rdr(12'h21C); chk(rd, 32'h01010001);
      rdr(12'h224); chk(rd, 32'h00000100);
      rdr(12'(($urandom % 133) * 4));
      chk(rd, 32'h0);
      chk(32'(rs), 32'h2);
      wr(12'h200, 32'h01000000);
      chk(32'(rs), 32'h2);
      // Random oscillator disable settings, reserved bits kept zero
      repeat (4) begin
         r = $urandom % 2;
         wr(12'h218, {7'h0, 1'(r), 24'h0}); cyc(2);
         chk(32'(osc_en), 32'(r == 0));
      end
      wr(12'h218, 32'h0);
      // Soft reset pulse length and self clearing
      wr(12'h220, 32'h01000000);
      chk(32'(rs), 32'h0);
      n = 0;
      while (srst === 1'b1) begin n++; @(posedge aclk); end
      chk(n, 2);
      rdr(12'h220); chk(rd, 32'h0);
      // Normal deep sleep with oscillator stop, then wake and settle
      @(posedge aclk); gs <= 1; @(posedge aclk); gs <= 0;
      while (!ack) @(posedge aclk);
      chk({cstop, osc_en}, 2'b10);
      cyc(1 + $urandom % 8); gw <= 1; @(posedge aclk); gw <= 0;
      while (!osc_en) @(posedge aclk);
      n = 0;
      while (cstop) begin n++; @(posedge aclk); end
      chk(n >= 4, 1);
      // Forced quiesce by test bit, oscillator kept running
      wr(12'h21C, 32'h01000000); cyc(4);
      chk({ack, cstop, osc_en}, 3'b111);
      wr(12'h21C, 32'h01000001); gw <= 1; @(posedge aclk); gw <= 0;
      cyc(12); chk({ack, cstop}, 2'b00);
      // Lock counting, loss and clearing of the lost flag
      pll(1, 3); chk(locked, 0);
      pll(1, 1); chk(locked, 1);
      rdr(12'h224); chk(rd, 32'h01000100);
      pll(0, 1); rdr(12'h224); chk(rd, 32'h00010100);
      wr(12'h224, 32'h00010100); rdr(12'h224); chk(rd, 32'h100);
      byp <= 1;
      repeat (4) begin @(posedge aclk); osc <= 1; cyc(2); osc <= 0; end
      cyc(4); chk(locked, 1);
      // Sequencer disabled: quiesce must not stop clocks
      wr(12'h21C, 32'h00000001); @(posedge aclk); gs <= 1;
      @(posedge aclk); gs <= 0; cyc(10); chk({ack, cstop}, 0);
      end_of_test;
   end
endmodule
`default_nettype wire
